// >>> src/codec_ctl_pkg.sv
// Constants, field layouts and helpers for the codec serial control port.
// Assumes a single 40 MHz system clock; all pins are sampled into that domain.
//
// Functional notes
// (R1) Format pin high or open selects full addressed format, low the short one.
// (R2) Timing mode comes from register 10 bit 9; continuous mode after reset.
// (R3) Burst timing only exists while the full addressed format is selected.
// (R4) Continuous mode: shift clock runs without pause at master clock over six.
// (R5) Burst mode: 18 master-rate pulses, guard, 16 data, guard.
// (R6) One receive sample per sample period, framed by strobe rising edge.
// (R7) Transmit words read twice per sample, one per strobe edge; host fills both.
// (R8) Full format word: 2-bit address, write/read flag, 13 data bits, MSB first.
// (R9) Address bits, upper first, pick one of four control registers.
// (R10) Register 00 bits 12:11 pick DAC source; code 00 bypasses and resets interpolator.
// (R11) Register 00 bit 10 sets transmit filter gain, 0 dB or 6 dB.
// (R12) Register 00 bits 9:2 hold N; full reading gives ratio 2N+34.
// (R13) Continuous mode honours low six bits; burst ignores top two, short reading.
// (R14) Register 00 bits 1:0 set speaker gain; 00 squelches to mid reference.
// (R15) Register 01 bit layout: loopback, test, mic gain, dither, line controls, relays.
// (R16) Four mic gains up to 20 dB; mic and line filter gains 0 or -4 dB.
// (R17) Line input, mic input or both may be routed into the ADC.
// (R18) Speaker driver source selectable, with attenuation, mute and power-down.
// (R19) Line driver source selectable among mic, line and transmit output.
// (R20) After supplies, internal reset first, then references power up, about 50 ms.
// (R21) Modulator rate 1.024 to 2.048 MHz; output rate from clock and decimation.
// (R22) Short reading of six-bit N gives ratio 2N+192, from 192 to 318.
// (R23) With readback enabled, a read frame returns address, flag and register contents.
// (R24) Host holds control and transmit bits stable around shift clock falling edge.
// (R25) Control word applied only after all 16 bits; fields default during power-on reset.
// (R26) Frame with write/read flag low leaves the addressed register unchanged.

package codec_ctl_pkg;

	localparam int WORD_BITS = 16;
	localparam int REG_BITS = 13;
	localparam int OSR_BITS = 10;

	// Register addresses and reset value
	localparam logic [1:0] REG_TX_PATH = 2'h0;
	localparam logic [1:0] REG_ROUTING = 2'h1;
	localparam logic [1:0] REG_MODE = 2'h2;
	localparam logic [1:0] REG_AUX = 2'h3;
	localparam logic [12:0] REG_RESET = 13'h0000;

	// Full format word layout
	localparam int WORD_ADDR_HI = 15;
	localparam int WORD_ADDR_LO = 14;
	localparam int WORD_WRITE = 13;

	// Field positions
	localparam int TIMING_MODE_BIT = 9;
	localparam int READBACK_BIT = 0;
	localparam int DAC_SRC_LSB = 11;
	localparam int TX_GAIN_BIT = 10;
	localparam int OSR_LSB = 2;
	localparam int SPK_GAIN_LSB = 0;
	localparam int ADC_LOOP_BIT = 12;
	localparam int TEST_OUT_BIT = 11;
	localparam int MIC_GAIN_LSB = 9;
	localparam int DITHER_BIT = 8;
	localparam int LINE_ATTEN_BIT = 7;
	localparam int LINE_EN_BIT = 6;
	localparam int LINE_SRC_HI_BIT = 5;
	localparam int LOCAL_LOOP_BIT = 4;
	localparam int REMOTE_LOOP_BIT = 3;
	localparam int RELAY_A_BIT = 2;
	localparam int SQUELCH_BIT = 1;
	localparam int RELAY_B_BIT = 0;

	// Timing
	localparam int CONT_DIV = 6;
	localparam int BURST_PULSES = 18;
	localparam logic [9:0] OSR_FULL_BASE = 10'h022;
	localparam logic [9:0] OSR_SHORT_BASE = 10'h0c0;
	localparam int POWERUP_MS = 50;
	localparam int CLK_KHZ = 40000;
	localparam int POWERUP_CYCLES = POWERUP_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		SCK_IDLE = 2'b00,
		SCK_BURST = 2'b01,
		SCK_CONT = 2'b10
	} sck_state_t;

	// Ratio from the N field per format and timing mode
	function automatic logic [9:0] osr_of(input logic [7:0] n, input logic full,
		input logic burst);
		logic [9:0] base;
		logic [9:0] nn;
		base = (full && !burst) ? OSR_FULL_BASE : OSR_SHORT_BASE;
		nn = {4'h0, n[5:0]};
		osr_of = base + {nn[8:0], 1'b0};
	endfunction

endpackage

// >>> src/codec_serial_control_port.sv
// Serial host port and control registers of the codec.
// Assumes master clock, data and strap pins are asynchronous to clk and
// slower than clk/4; ADC samples arrive on adc_sample from the converter side.
`timescale 1ns/1ps
`default_nettype none

module codec_serial_control_port #(
	parameter int POWERUP_COUNT = codec_ctl_pkg::POWERUP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic por_b,
	input wire logic format_select_pin,
	input wire logic master_clock_in,
	input wire logic tx_serial_in,
	input wire logic control_serial_in,
	input wire logic [15:0] adc_sample,
	output logic shift_clock_out,
	output logic strobe_out,
	output logic rx_serial_out,
	output logic [15:0] tx_word,
	output logic tx_word_valid,
	output logic tx_word_second,
	output logic internal_reset,
	output logic refs_ready,
	output logic burst_timing,
	output logic [1:0] dac_source,
	output logic interp_reset,
	output logic tx_filter_gain,
	output logic [9:0] osr_ratio,
	output logic [1:0] speaker_gain,
	output logic speaker_squelch,
	output logic adc_loopback_en,
	output logic test_out_en,
	output logic [1:0] mic_gain,
	output logic dither_en,
	output logic line_atten_en,
	output logic line_in_ctrl,
	output logic [1:0] line_driver_src,
	output logic local_analog_loop,
	output logic line_driver_squelch,
	output logic [12:0] mode_reg,
	output logic [12:0] aux_reg,
	output logic offhook_relay_out,
	output logic offhook_relay_oe,
	output logic talk_data_relay_out,
	output logic talk_data_relay_oe
);
	initial begin
		if (POWERUP_COUNT < 1 || POWERUP_COUNT > 2097151)
			$error("POWERUP_COUNT out of range");
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic por_ok, full_fmt, mclk_rise, mclk_fall, tx_bit, ctl_bit;

	pin_sync #(.RESET_LEVEL(1'b0)) u_por (.clk(clk), .rst_b(rst_b), .pin(por_b),
		.level(por_ok), .rise(), .fall());
	pin_sync #(.RESET_LEVEL(1'b1)) u_fmt (.clk(clk), .rst_b(rst_b), .pin(format_select_pin),
		.level(full_fmt), .rise(), .fall());
	pin_sync #(.RESET_LEVEL(1'b0)) u_mclk (.clk(clk), .rst_b(rst_b), .pin(master_clock_in),
		.level(), .rise(mclk_rise), .fall(mclk_fall));
	pin_sync #(.RESET_LEVEL(1'b0)) u_tx (.clk(clk), .rst_b(rst_b), .pin(tx_serial_in),
		.level(tx_bit), .rise(), .fall());
	pin_sync #(.RESET_LEVEL(1'b0)) u_ctl (.clk(clk), .rst_b(rst_b), .pin(control_serial_in),
		.level(ctl_bit), .rise(), .fall());

	// Both the bench reset and the power-on pin clear the port
	logic run;
	assign run = rst_b & por_ok;

	// ------------------------------------------------------------
	// Power-up sequence
	// ------------------------------------------------------------
	logic [20:0] pwr_cnt;

	always_ff @(posedge clk) begin
		if (!run) begin
			pwr_cnt <= '0;
			refs_ready <= 1'b0;
		end else if (pwr_cnt == POWERUP_COUNT[20:0] - 21'h000001) begin
			refs_ready <= 1'b1; // R20
		end else begin
			pwr_cnt <= pwr_cnt + 21'h000001;
		end
	end

	assign internal_reset = ~run; // R20

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [12:0] regs [4];
	logic [9:0] osr;
	logic burst;

	assign burst = full_fmt & regs[codec_ctl_pkg::REG_MODE][codec_ctl_pkg::TIMING_MODE_BIT]; // R2 R3
	assign osr = codec_ctl_pkg::osr_of(regs[codec_ctl_pkg::REG_TX_PATH][9:2], full_fmt,
		burst); // R12 R13 R22

	// ------------------------------------------------------------
	// Shift clock generation
	// ------------------------------------------------------------
	codec_ctl_pkg::sck_state_t sck_state;
	logic [2:0] div_cnt;
	logic [4:0] pulse_cnt;
	logic [9:0] half_cnt;
	logic sck_rise, sck_fall, word_start, data_fall, shift_rise;

	always_comb begin
		sck_rise = 1'b0;
		sck_fall = 1'b0;
		word_start = 1'b0;
		data_fall = 1'b0;
		shift_rise = 1'b0;
		case (sck_state)
			codec_ctl_pkg::SCK_CONT: begin
				sck_rise = mclk_rise && div_cnt == 3'(codec_ctl_pkg::CONT_DIV - 1); // R4
				sck_fall = mclk_rise && div_cnt == 3'(codec_ctl_pkg::CONT_DIV / 2 - 1);
				word_start = sck_rise && pulse_cnt == 5'h0f;
				data_fall = sck_fall;
				shift_rise = sck_rise && !word_start;
			end
			codec_ctl_pkg::SCK_BURST: begin
				sck_rise = mclk_rise && pulse_cnt < 5'(codec_ctl_pkg::BURST_PULSES); // R5
				sck_fall = mclk_fall && shift_clock_out;
				data_fall = sck_fall && pulse_cnt >= 5'h02 && pulse_cnt <= 5'h11;
				shift_rise = sck_rise && pulse_cnt >= 5'h02 && pulse_cnt <= 5'h10;
			end
			default: begin
				sck_rise = 1'b0;
			end
		endcase
		if (sck_state != codec_ctl_pkg::SCK_CONT)
			word_start = mclk_rise && half_cnt >= osr - 10'h001;
	end

	always_ff @(posedge clk) begin
		if (!run) begin
			sck_state <= codec_ctl_pkg::SCK_CONT;
		end else if (word_start || sck_state == codec_ctl_pkg::SCK_IDLE) begin
			// Mode change lands only on a word boundary so no half word escapes
			sck_state <= burst ? codec_ctl_pkg::SCK_BURST : codec_ctl_pkg::SCK_CONT;
		end
	end

	always_ff @(posedge clk) begin
		if (!run || sck_state != codec_ctl_pkg::SCK_CONT) begin
			div_cnt <= '0;
		end else if (mclk_rise) begin
			div_cnt <= (div_cnt == 3'(codec_ctl_pkg::CONT_DIV - 1)) ? 3'h0 : div_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!run) begin
			half_cnt <= '0;
		end else if (word_start) begin
			half_cnt <= '0;
		end else if (mclk_rise) begin
			half_cnt <= half_cnt + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!run) begin
			pulse_cnt <= 5'(codec_ctl_pkg::BURST_PULSES);
			shift_clock_out <= 1'b0;
		end else begin
			// Entering burst, the last continuous rise doubles as the guard pulse
			if (word_start && burst && sck_state == codec_ctl_pkg::SCK_CONT)
				pulse_cnt <= 5'h01; // R5
			else if (word_start)
				pulse_cnt <= '0;
			else if (sck_rise)
				pulse_cnt <= pulse_cnt + 5'h01;
			if (sck_state == codec_ctl_pkg::SCK_BURST && word_start)
				shift_clock_out <= 1'b0;
			else if (sck_rise)
				shift_clock_out <= 1'b1;
			else if (sck_fall)
				shift_clock_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Strobe and receive data
	// ------------------------------------------------------------
	logic [15:0] rx_shift;
	logic rb_pending;
	logic [15:0] rb_word;

	always_ff @(posedge clk) begin
		if (!run) begin
			strobe_out <= 1'b0;
			rx_shift <= '0;
		end else if (word_start) begin
			strobe_out <= ~strobe_out; // R7
			if (!strobe_out)
				rx_shift <= adc_sample; // R6
			else
				rx_shift <= rb_pending ? rb_word : 16'h0000; // R23
		end else if (shift_rise) begin
			rx_shift <= {rx_shift[14:0], 1'b0};
		end
	end

	assign rx_serial_out = rx_shift[15];

	// ------------------------------------------------------------
	// Input words
	// ------------------------------------------------------------
	logic [15:0] ctl_word;
	logic ctl_full, ctl_full_d;

	// Sampling on the falling shift clock edge, where the host holds data
	serial_shift #(.WIDTH(codec_ctl_pkg::WORD_BITS)) u_txs (.clk(clk), .rst_b(run),
		.clear(word_start), .shift(data_fall), .bit_in(tx_bit), .word(tx_word),
		.full()); // R24
	serial_shift #(.WIDTH(codec_ctl_pkg::WORD_BITS)) u_ctls (.clk(clk), .rst_b(run),
		.clear(word_start), .shift(data_fall), .bit_in(ctl_bit), .word(ctl_word),
		.full(ctl_full));

	always_ff @(posedge clk) begin
		if (!run) begin
			ctl_full_d <= 1'b0;
		end else begin
			ctl_full_d <= ctl_full;
		end
	end

	logic word_done;
	assign word_done = ctl_full & ~ctl_full_d;
	assign tx_word_valid = word_done; // R7
	assign tx_word_second = ~strobe_out;

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	logic [1:0] w_addr;
	logic w_write;
	logic apply;

	assign w_addr = {ctl_word[codec_ctl_pkg::WORD_ADDR_HI],
		ctl_word[codec_ctl_pkg::WORD_ADDR_LO]}; // R9
	assign w_write = ctl_word[codec_ctl_pkg::WORD_WRITE];
	// Control words are taken in the strobe-high slot only, once per sample
	assign apply = word_done & strobe_out; // R25

	always_ff @(posedge clk) begin
		if (!run) begin
			for (int i = 0; i < 4; i++)
				regs[i] <= codec_ctl_pkg::REG_RESET; // R25
		end else if (apply && full_fmt) begin
			if (w_write)
				regs[w_addr] <= ctl_word[12:0]; // R8 R9 R26
		end else if (apply) begin
			// Short format carries a subset of registers 00 and 01
			regs[codec_ctl_pkg::REG_TX_PATH] <= {ctl_word[15:14], ctl_word[7], 2'b00,
				ctl_word[13:8], ctl_word[5:4]}; // R1 R22
			regs[codec_ctl_pkg::REG_ROUTING][codec_ctl_pkg::LOCAL_LOOP_BIT] <= ctl_word[6];
			regs[codec_ctl_pkg::REG_ROUTING][codec_ctl_pkg::REMOTE_LOOP_BIT] <= ctl_word[3];
			regs[codec_ctl_pkg::REG_ROUTING][2:0] <= ctl_word[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!run) begin
			rb_pending <= 1'b0;
			rb_word <= '0;
		end else if (apply && full_fmt && !w_write &&
			regs[codec_ctl_pkg::REG_MODE][codec_ctl_pkg::READBACK_BIT]) begin
			rb_pending <= 1'b1; // R23
			rb_word <= {w_addr, 1'b0, regs[w_addr]};
		end else if (word_start && strobe_out) begin
			rb_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	logic [12:0] r0, r1;
	assign r0 = regs[codec_ctl_pkg::REG_TX_PATH];
	assign r1 = regs[codec_ctl_pkg::REG_ROUTING];

	always_ff @(posedge clk) begin
		if (!run) begin
			osr_ratio <= codec_ctl_pkg::OSR_FULL_BASE;
			burst_timing <= 1'b0;
		end else begin
			osr_ratio <= osr; // R12 R13 R21
			burst_timing <= sck_state == codec_ctl_pkg::SCK_BURST;
		end
	end

	assign dac_source = r0[12:11]; // R10
	assign interp_reset = r0[12:11] == 2'b00; // R10
	assign tx_filter_gain = r0[codec_ctl_pkg::TX_GAIN_BIT]; // R11
	assign speaker_gain = r0[1:0]; // R14 R18
	assign speaker_squelch = r0[1:0] == 2'b00; // R14
	assign adc_loopback_en = r1[codec_ctl_pkg::ADC_LOOP_BIT]; // R15
	assign test_out_en = r1[codec_ctl_pkg::TEST_OUT_BIT];
	assign mic_gain = r1[10:9]; // R16
	assign dither_en = r1[codec_ctl_pkg::DITHER_BIT];
	assign line_atten_en = r1[codec_ctl_pkg::LINE_ATTEN_BIT]; // R16
	assign line_in_ctrl = r1[codec_ctl_pkg::LINE_EN_BIT]; // R17
	assign line_driver_src = {r1[codec_ctl_pkg::LINE_SRC_HI_BIT],
		r1[codec_ctl_pkg::REMOTE_LOOP_BIT]}; // R19
	assign local_analog_loop = r1[codec_ctl_pkg::LOCAL_LOOP_BIT];
	assign line_driver_squelch = r1[codec_ctl_pkg::SQUELCH_BIT];
	assign mode_reg = regs[codec_ctl_pkg::REG_MODE];
	assign aux_reg = regs[codec_ctl_pkg::REG_AUX];

	// Open-drain relays pull low when active; relay B also gated by power-on
	assign offhook_relay_out = 1'b0;
	assign offhook_relay_oe = r1[codec_ctl_pkg::RELAY_A_BIT];
	assign talk_data_relay_out = 1'b0;
	assign talk_data_relay_oe = r1[codec_ctl_pkg::RELAY_B_BIT] & por_ok;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_read_frame;
		apply && full_fmt && !w_write && regs[codec_ctl_pkg::REG_MODE][0];
	endsequence

	a_burst_needs_full: assert property (@(posedge clk) disable iff (!run) // R3
		word_start && !full_fmt |=> ##1 !burst_timing)
		else $error("burst timing without full format");
	a_cont_divide_six: assert property (@(posedge clk) disable iff (!run) // R4
		sck_state == codec_ctl_pkg::SCK_CONT && sck_rise |-> div_cnt == 3'h5)
		else $error("continuous clock not at one sixth");
	a_burst_pulse_cap: assert property (@(posedge clk) disable iff (!run) // R5
		sck_state == codec_ctl_pkg::SCK_BURST && sck_rise |-> pulse_cnt < 5'h12)
		else $error("burst exceeds eighteen pulses");
	a_sample_on_rise: assert property (@(posedge clk) disable iff (!run) // R6
		word_start && !strobe_out |=> strobe_out && rx_shift == $past(adc_sample))
		else $error("sample not loaded at strobe rise");
	a_nowrite_on_read: assert property (@(posedge clk) disable iff (!run) // R26
		apply && full_fmt && !w_write |=> regs[$past(w_addr)] == $past(regs[w_addr]))
		else $error("read frame altered register");
	a_write_lands: assert property (@(posedge clk) disable iff (!run) // R8
		apply && full_fmt && w_write |=> regs[$past(w_addr)] == $past(ctl_word[12:0]))
		else $error("write frame not stored");
	a_readback_word: assert property (@(posedge clk) disable iff (!run) // R23
		s_read_frame |=> rb_pending && rb_word[15:13] == {$past(w_addr), 1'b0})
		else $error("readback word wrong");
	a_squelch_code: assert property (@(posedge clk) disable iff (!run) // R14
		speaker_squelch == (speaker_gain == 2'b00)) else $error("squelch decode wrong");
	a_osr_full_range: assert property (@(posedge clk) disable iff (!run) // R12
		full_fmt && !burst |=> osr_ratio >= 10'h022 && osr_ratio <= 10'h0a0)
		else $error("full ratio out of range");
	a_defaults_reset: assert property (@(posedge clk) !run |=> regs[0] == 13'h0000) // R25
		else $error("registers not defaulted");
endmodule

`default_nettype wire

// >>> src/pin_sync.sv
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta <= RESET_LEVEL;
			sync <= RESET_LEVEL;
			prev <= RESET_LEVEL;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule

`default_nettype wire

// >>> src/serial_shift.sv
// Serial-in shifter, MSB first, with a cleared bit count.
// Assumes shift and clear are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none

module serial_shift #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic shift,
	input wire logic bit_in,
	output logic [WIDTH-1:0] word,
	output logic full
);
	logic [$clog2(WIDTH+1)-1:0] count;

	initial begin
		if (WIDTH < 2) $error("serial_shift: WIDTH below 2");
	end

	always_ff @(posedge clk) begin
		if (!rst_b || clear) begin
			word <= '0;
			count <= '0;
		end else if (shift && !full) begin
			word <= {word[WIDTH-2:0], bit_in};
			count <= count + 1'b1;
		end
	end

	assign full = (count == WIDTH[$clog2(WIDTH+1)-1:0]);
endmodule

`default_nettype wire

// >>> tb/pump_model.sv
// Host-side model of the serial port: master clock, control and transmit words.
// Assumes the device shifts on its own clock; edges are seen in the clk domain.
`timescale 1ns/1ps
`default_nettype none

module pump_model #(
	parameter logic [15:0] TXH = 16'hc3a5,
	parameter logic [15:0] TXL = 16'h5a3c
) (
	input wire logic clk,
	input wire logic sck,
	input wire logic strobe,
	input wire logic rx,
	input wire logic [15:0] ctl_next,
	output logic mclk,
	output logic tx,
	output logic ctl,
	output logic [15:0] rx_high,
	output logic [15:0] rx_low,
	output int starts
);
	logic sck_q = 1'b0;
	logic stb_q = 1'b0;
	logic [15:0] tx_sh = 16'h0000;
	logic [15:0] ctl_sh = 16'h0000;
	logic [15:0] rx_sh = 16'h0000;
	int pos = 0;

	// Phase unrelated to clk on purpose
	initial begin
		mclk = 1'b0;
		starts = 0;
		#37;
		forever #100 mclk = ~mclk;
	end

	assign tx = tx_sh[15];
	assign ctl = ctl_sh[15];

	// Data moves one clk after the shift clock rises, so it is steady at the fall
	always @(posedge clk) begin
		sck_q <= sck;
		stb_q <= strobe;
		if (strobe != stb_q) begin
			// Continuous slots start on a shift clock rise, burst slots before the guard
			tx_sh <= strobe ? TXH : TXL;
			ctl_sh <= strobe ? ctl_next : 16'h0000;
			pos <= (sck && !sck_q) ? 2 : 0;
			if (stb_q) begin
				rx_high <= rx_sh;
			end else begin
				rx_low <= rx_sh;
			end
			if (strobe) begin
				starts <= starts + 1;
			end
		end else if (sck && !sck_q) begin
			// Guard and first data pulse of a burst leave the MSB standing
			pos <= pos + 1;
			if (pos >= 2) begin
				tx_sh <= {tx_sh[14:0], 1'b0};
				ctl_sh <= {ctl_sh[14:0], 1'b0};
			end
		end
		if (!sck && sck_q && pos >= 2 && pos <= 17) begin
			rx_sh <= {rx_sh[14:0], rx};
		end
	end
endmodule

`default_nettype wire

// >>> tb/test_codec_serial_control_port.sv
// Self-checking bench for the codec serial control port.
// Assumes pump_model plays the host on the serial pins.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("wrong value at %0t: %h vs %h", $time, got, exp); \
	end \
end

module test_codec_serial_control_port;
	localparam logic [15:0] TXH = 16'hc3a5;
	localparam logic [15:0] TXL = 16'h5a3c;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int starts;
	logic clk, rst_b, por_b, format_select_pin, master_clock_in, tx_serial_in;
	logic control_serial_in, shift_clock_out, strobe_out, rx_serial_out, tx_word_valid;
	logic tx_word_second, internal_reset, refs_ready, burst_timing, interp_reset;
	logic tx_filter_gain, speaker_squelch, adc_loopback_en, test_out_en, dither_en;
	logic line_atten_en, line_in_ctrl, local_analog_loop, line_driver_squelch;
	logic offhook_relay_out, offhook_relay_oe, talk_data_relay_out, talk_data_relay_oe;
	logic [1:0] dac_source, speaker_gain, mic_gain, line_driver_src;
	logic [15:0] tx_word, adc_sample, ctl_next, rx_high, rx_low;
	logic [12:0] mode_reg, aux_reg;
	logic [9:0] osr_ratio;
	wire logic [4:0] r00 = {dac_source, tx_filter_gain, speaker_gain};
	wire logic [12:0] r01 = {adc_loopback_en, test_out_en, mic_gain, dither_en,
		line_atten_en, line_in_ctrl, line_driver_src[1], local_analog_loop,
		line_driver_src[0], offhook_relay_oe, line_driver_squelch, talk_data_relay_oe};

	codec_serial_control_port #(.POWERUP_COUNT(20)) codec_serial_control_port_i (
		.clk, .rst_b, .por_b, .format_select_pin, .master_clock_in, .tx_serial_in,
		.control_serial_in, .adc_sample, .shift_clock_out, .strobe_out, .rx_serial_out,
		.tx_word, .tx_word_valid, .tx_word_second, .internal_reset, .refs_ready,
		.burst_timing, .dac_source, .interp_reset, .tx_filter_gain, .osr_ratio,
		.speaker_gain, .speaker_squelch, .adc_loopback_en, .test_out_en, .mic_gain,
		.dither_en, .line_atten_en, .line_in_ctrl, .line_driver_src, .local_analog_loop,
		.line_driver_squelch, .mode_reg, .aux_reg, .offhook_relay_out, .offhook_relay_oe,
		.talk_data_relay_out, .talk_data_relay_oe);

	pump_model #(.TXH(TXH), .TXL(TXL)) pump_model_i (
		.clk(clk), .sck(shift_clock_out), .strobe(strobe_out), .rx(rx_serial_out),
		.ctl_next(ctl_next), .mclk(master_clock_in), .tx(tx_serial_in),
		.ctl(control_serial_in), .rx_high(rx_high), .rx_low(rx_low), .starts(starts));

	// --------------------------------
	// Helpers
	// --------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Three slot starts: the word surely travels whole at least once
	task automatic send(input logic [15:0] w);
		int s;
		ctl_next = w;
		s = starts + 3;
		while (starts < s) tick(1);
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_reset();
		tick(2);
		`CHECK(internal_reset, 1'b1)
		rst_b = 1'b1;
		tick(1);
		`CHECK(refs_ready, 1'b0)
		`CHECK({r00, interp_reset, speaker_squelch, burst_timing}, 8'h06)
		`CHECK(osr_ratio, 10'h022)
		`CHECK(r01, 13'h0000)
		tick(25);
		`CHECK(refs_ready, 1'b1)
	endtask

	task automatic t_regs();
		logic [12:0] d;
		send({3'b001, 13'h1715});
		`CHECK({r00, interp_reset, speaker_squelch}, 7'h54)
		`CHECK(osr_ratio, 10'h02c)
		for (int i = 0; i < 2; i++) begin
			d = i ? 13'h0555 : 13'h1aaa;
			send({3'b011, d});
			`CHECK(r01, d)
			`CHECK({offhook_relay_out, talk_data_relay_out}, 2'b00)
		end
		send(16'h0000);
		`CHECK(r00, 5'h15)
	endtask

	task automatic t_stream();
		int n;
		for (int i = 0; i < 4; i++) begin
			while (tx_word_valid !== 1'b1) tick(1);
			`CHECK(tx_word, tx_word_second ? TXL : TXH)
			tick(1);
		end
		`CHECK(rx_high, adc_sample)
		while (shift_clock_out !== 1'b0) tick(1);
		while (shift_clock_out !== 1'b1) tick(1);
		n = 0;
		while (shift_clock_out === 1'b1) begin tick(1); n++; end
		while (shift_clock_out === 1'b0) begin tick(1); n++; end
		`CHECK(n, 48)
	endtask

	task automatic t_readback();
		send(16'ha001);
		`CHECK(mode_reg, 13'h0001)
		send(16'h4000);
		`CHECK(rx_low, 16'h4555)
		`CHECK(r01, 13'h0555)
	endtask

	task automatic t_format();
		send(16'hff65);
		`CHECK(aux_reg, 13'h1f65)
		format_select_pin = 1'b0;
		send(16'hff65);
		`CHECK(r00, 5'h1a)
		`CHECK(osr_ratio, 10'h13e)
		`CHECK(r01[4:0], 5'h15)
		format_select_pin = 1'b1;
		send(16'hff65);
		`CHECK(osr_ratio, 10'h0a0)
	endtask

	task automatic t_burst();
		int n, g;
		logic p;
		ctl_next = 16'ha201;
		while (burst_timing !== 1'b1) tick(1);
		// A read frame is harmless even if the guard pulse misaligns it
		ctl_next = 16'h8000;
		tick(2);
		`CHECK(osr_ratio, 10'h13e)
		g = 0;
		while (g < 40) begin tick(1); g = shift_clock_out ? 0 : g + 1; end
		p = 1'b0;
		n = 0;
		g = 0;
		while (g < 40) begin
			tick(1);
			if (shift_clock_out && !p) n++;
			g = (shift_clock_out || n == 0) ? 0 : g + 1;
			p = shift_clock_out;
		end
		`CHECK(n, 18)
		for (int i = 0; i < 2; i++) begin
			while (tx_word_valid !== 1'b1) tick(1);
			`CHECK(tx_word, tx_word_second ? TXL : TXH)
			tick(1);
		end
		`CHECK(rx_high, adc_sample)
		format_select_pin = 1'b0;
		n = 0;
		while (burst_timing !== 1'b0 && n < 5000) begin tick(1); n++; end
		`CHECK(burst_timing, 1'b0)
		`CHECK(mode_reg[9], 1'b1)
	endtask

	task automatic t_por();
		format_select_pin = 1'b1;
		por_b = 1'b0;
		tick(4);
		`CHECK(internal_reset, 1'b1)
		por_b = 1'b1;
		tick(4);
		`CHECK({mode_reg, r01, burst_timing}, 27'h0000000)
	endtask

	initial begin
		rst_b = 1'b0;
		por_b = 1'b1;
		format_select_pin = 1'b1;
		adc_sample = 16'h9b1e;
		ctl_next = 16'h0000;
		t_reset();
		t_regs();
		t_stream();
		t_readback();
		t_format();
		t_burst();
		t_por();
		test_done();
	end
endmodule

`default_nettype wire
